// [rtl/quiet_skip_burst_fault_control.sv]
// Purpose: Quiet-skip burst sequencing, minimum peak bin tuning, fault handling
// Assumes: Comparator flags asynchronous; one sys_clk at 10 MHz; sync reset
// Notes: Drive pulse edges are reported by drive_on from the power stage
//
// Summary of operation
// - Quiet timer caps burst rate at 800 Hz
// - Enter burst at 25 kHz, finish pulse
// - Skip exit resumes pulses, starts timer, counter
// - Skip entry stops after third pulse ends
// - No restart before quiet timer expires
// - Timer expiry alone never starts burst
// - Above 1 V leave burst immediately
// - Sample output voltage at demagnetization end
// - Minimum peak threshold follows sensed voltage
// - Eighteen bins map to fixed threshold codes
// - Faults sorted: latch, restart, auto-recover
// - Latching faults disable driver at once
// - Latched: no restart at turn-on level
// - Latch clears on supply reset, line removal
// - Skip below level, resume above hysteresis
// - Non-latching fault restarts at next turn-on
`timescale 1ns/1ns
module quiet_skip_burst_fault_control
    import qsk_pkg::*;
#(
    parameter int unsigned QUIET_COUNT = QUIET_CYCLES,
    parameter int unsigned AUTOREC_COUNT = AUTOREC_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic feedback_level_below_skip,
    input wire logic feedback_level_above_exit,
    input wire logic feedback_level_above_1v,
    input wire logic freq_at_25khz,
    input wire logic valley_detect,
    input wire logic zero_cross_sense_demag_end,
    input wire logic drive_pulse_active,
    input wire logic [4:0] zero_cross_sense_bin,
    input wire logic abnormal_overcurrent_fault,
    input wire logic overvoltage_fault,
    input wire logic latch_input,
    input wire logic nonlatch_fault,
    input wire logic autorec_fault,
    input wire logic supply_turn_on_level,
    input wire logic supply_reset_level,
    input wire logic line_removal,
    output logic gate_drive_output,
    output logic burst_active,
    output logic [7:0] cs_min_code,
    output logic [4:0] sensed_bin,
    output logic [1:0] fault_mode,
    output logic fault_latched
);
    localparam int QW = $clog2(QUIET_COUNT + 1);
    localparam int AW = $clog2(AUTOREC_COUNT + 1);

    // =====================================================================
    // Input synchronisation
    // =====================================================================
    flags_s raw;
    flags_s f;
    logic [4:0] bin_m_q;
    logic [4:0] bin_s_q;
    logic [4:0] bin_t_q;

    always_comb begin
        raw.skip_below = feedback_level_below_skip;
        raw.skip_exit = feedback_level_above_exit;
        raw.burst_exit = feedback_level_above_1v;
        raw.freq_at_min = freq_at_25khz;
        raw.valley = valley_detect;
        raw.demag_end = zero_cross_sense_demag_end;
        raw.drive_on = drive_pulse_active;
        raw.abnormal_overcurrent_fault = abnormal_overcurrent_fault;
        raw.overvoltage_fault = overvoltage_fault;
        raw.latch_input = latch_input;
        raw.nonlatch_fault = nonlatch_fault;
        raw.autorec_fault = autorec_fault;
        raw.supply_turn_on_level = supply_turn_on_level;
        raw.supply_reset_level = supply_reset_level;
        raw.line_removal = line_removal;
    end

    flag_sync u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .flags_raw(raw),
        .flags_sync(f)
    );

    // Bin code from the sense quantiser, synchronised as a level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bin_m_q <= '0;
            bin_s_q <= '0;
            bin_t_q <= '0;
        end else begin
            bin_m_q <= zero_cross_sense_bin;
            bin_s_q <= bin_m_q;
            bin_t_q <= bin_s_q;
        end
    end

    function automatic logic [7:0] bin_to_code(input logic [4:0] b);
        logic [4:0] c;
        c = (b > BIN_MAX) ? BIN_MAX : b;
        return CS_MIN_MV[c];
    endfunction : bin_to_code

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        burst_e st;
        logic [QW-1:0] quiet_cnt;
        logic [1:0] pulse_cnt;
        logic stop_req;
        logic drive_prev;
        logic demag_prev;
        logic [4:0] bin;
        logic [7:0] code;
        fault_mode_e mode;
        logic latched;
        logic burst;
        logic [AW-1:0] ar_cnt;
        logic gate;
        logic supply_on_prev;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic pulse_end;
    logic demag_rise;
    logic quiet_done;
    logic latch_hit;
    logic on_rise;
    logic any_fault;

    always_comb begin
        pulse_end = s_q.drive_prev && !f.drive_on;
        demag_rise = f.demag_end && !s_q.demag_prev;
        quiet_done = (s_q.quiet_cnt == '0);
        latch_hit = f.abnormal_overcurrent_fault || f.overvoltage_fault || f.latch_input;
        on_rise = f.supply_turn_on_level && !s_q.supply_on_prev;
        any_fault = latch_hit || f.nonlatch_fault || f.autorec_fault;
    end

    always_comb begin
        s_d = s_q;
        s_d.drive_prev = f.drive_on;
        s_d.demag_prev = f.demag_end;
        s_d.supply_on_prev = f.supply_turn_on_level;

        // Quiet timer counts down to zero
        if (!quiet_done) begin
            s_d.quiet_cnt = s_q.quiet_cnt - QW'(1);
        end

        // Pulse counter saturates at three
        if (pulse_end && s_q.pulse_cnt != BURST_PULSES) begin
            s_d.pulse_cnt = s_q.pulse_cnt + 2'h1;
        end

        // Output voltage sample at demag end, steady bin word only
        if (demag_rise && bin_s_q == bin_t_q) begin
            s_d.bin = (bin_s_q > BIN_MAX) ? BIN_MAX : bin_s_q;
            s_d.code = bin_to_code(bin_s_q);
        end

        // =================================================================
        // Fault classification and recovery
        // =================================================================
        if (latch_hit) begin
            s_d.mode = FM_LATCH;
            s_d.latched = 1'b1;
        end else if (s_q.mode != FM_LATCH && f.autorec_fault) begin
            s_d.mode = FM_AUTOREC;
            s_d.ar_cnt = AW'(AUTOREC_COUNT);
        end else if (s_q.mode == FM_NONE && f.nonlatch_fault) begin
            s_d.mode = FM_RESTART;
        end

        case (s_q.mode)
            FM_LATCH: begin
                if (!latch_hit && (f.supply_reset_level || f.line_removal)) begin
                    s_d.mode = FM_RESTART;
                    s_d.latched = 1'b0;
                end
            end
            FM_RESTART: begin
                // Restart only once fault gone and supply reaches turn-on
                if (!any_fault && on_rise) begin
                    s_d.mode = FM_NONE;
                end
            end
            FM_AUTOREC: begin
                if (s_q.ar_cnt != '0) begin
                    s_d.ar_cnt = s_q.ar_cnt - AW'(1);
                end else if (!f.autorec_fault && on_rise) begin
                    s_d.mode = FM_NONE;
                end
            end
            default: begin
            end
        endcase

        // =================================================================
        // Burst sequencer
        // =================================================================
        case (s_q.st)
            ST_RUN: begin
                s_d.gate = 1'b1;
                if (f.freq_at_min && f.skip_below) begin
                    s_d.stop_req = 1'b1;
                end
                if ((s_q.stop_req || (f.freq_at_min && f.skip_below))
                        && pulse_end) begin
                    s_d.st = ST_BURST_OFF;
                    s_d.gate = 1'b0;
                    s_d.stop_req = 1'b0;
                end
            end
            ST_BURST_OFF: begin
                s_d.gate = 1'b0;
                if (f.burst_exit) begin
                    s_d.st = ST_RUN;
                    s_d.gate = 1'b1;
                end else if (f.skip_exit && quiet_done) begin
                    s_d.st = ST_BURST_ON;
                    s_d.gate = 1'b1;
                    s_d.quiet_cnt = QW'(QUIET_COUNT);
                    s_d.pulse_cnt = 2'h0;
                    s_d.stop_req = 1'b0;
                end
            end
            ST_BURST_ON: begin
                s_d.gate = 1'b1;
                if (f.skip_below) begin
                    s_d.stop_req = 1'b1;
                end
                if (f.burst_exit) begin
                    s_d.st = ST_RUN;
                    s_d.stop_req = 1'b0;
                end else if ((s_q.stop_req || f.skip_below) && pulse_end
                        && s_d.pulse_cnt == BURST_PULSES) begin
                    s_d.st = ST_BURST_OFF;
                    s_d.gate = 1'b0;
                    s_d.stop_req = 1'b0;
                end
            end
            ST_FAULT: begin
                s_d.gate = 1'b0;
                if (s_q.mode == FM_NONE && s_d.mode == FM_NONE) begin
                    s_d.st = ST_RUN;
                    s_d.gate = 1'b1;
                end
            end
            default: begin
                s_d.st = ST_FAULT;
                s_d.gate = 1'b0;
            end
        endcase

        // Faults override the sequencer at once
        if (any_fault || s_d.mode != FM_NONE) begin
            s_d.st = ST_FAULT;
            s_d.gate = 1'b0;
            s_d.stop_req = 1'b0;
        end
        s_d.burst = (s_d.st == ST_BURST_ON) || (s_d.st == ST_BURST_OFF);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q.st <= ST_FAULT;
            s_q.quiet_cnt <= '0;
            s_q.pulse_cnt <= 2'h0;
            s_q.stop_req <= 1'b0;
            s_q.drive_prev <= 1'b0;
            s_q.demag_prev <= 1'b0;
            s_q.bin <= BIN_RESET;
            s_q.code <= CS_MIN_RESET;
            s_q.mode <= FM_NONE;
            s_q.latched <= 1'b0;
            s_q.burst <= 1'b0;
            s_q.ar_cnt <= '0;
            s_q.gate <= 1'b0;
            s_q.supply_on_prev <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign gate_drive_output = s_q.gate;
    assign burst_active = s_q.burst;
    assign cs_min_code = s_q.code;
    assign sensed_bin = s_q.bin;
    assign fault_mode = s_q.mode;
    assign fault_latched = s_q.latched;

endmodule : quiet_skip_burst_fault_control

// [rtl/qsk_pkg.sv]
// Purpose: Shared constants and carrier types for the burst and fault controller
// Assumes: 10 MHz system clock
// Notes: Times kept in their own unit, cycle counts derived from them
package qsk_pkg;

    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned QUIET_US = 1250;
    localparam int unsigned QUIET_CYCLES = (QUIET_US * (CLK_HZ / 1000000));
    localparam int unsigned AUTOREC_MS = 1200;
    localparam int unsigned AUTOREC_CYCLES = AUTOREC_MS * (CLK_HZ / 1000);
    localparam logic [1:0] BURST_PULSES = 2'h3;
    localparam logic [4:0] BIN_MAX = 5'h11;
    // Threshold codes in mV, bin 0 to bin 17
    localparam logic [7:0] CS_MIN_MV [0:17] = '{
        8'h50, 8'h5A, 8'h64, 8'h6E, 8'h78, 8'h7D, 8'h87, 8'h8C, 8'h96,
        8'h9B, 8'hA0, 8'hA5, 8'hAF, 8'hB4, 8'hB9, 8'hBE, 8'hC3, 8'hC8
    };
    localparam logic [7:0] CS_MIN_RESET = 8'hC8;
    localparam logic [4:0] BIN_RESET = 5'h11;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic skip_below;
        logic skip_exit;
        logic burst_exit;
        logic freq_at_min;
        logic valley;
        logic demag_end;
        logic drive_on;
        logic abnormal_overcurrent_fault;
        logic overvoltage_fault;
        logic latch_input;
        logic nonlatch_fault;
        logic autorec_fault;
        logic supply_turn_on_level;
        logic supply_reset_level;
        logic line_removal;
    } flags_s;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_BURST_ON = 4'h2,
        ST_BURST_OFF = 4'h4,
        ST_FAULT = 4'h8
    } burst_e;

    typedef enum logic [1:0] {
        FM_NONE = 2'h0,
        FM_LATCH = 2'h1,
        FM_RESTART = 2'h2,
        FM_AUTOREC = 2'h3
    } fault_mode_e;

endpackage : qsk_pkg

// [rtl/flag_sync.sv]
// Purpose: Two-stage synchroniser for a bundle of comparator flags
// Assumes: Flags are asynchronous to sys_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module flag_sync
    import qsk_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire flags_s flags_raw,
    output flags_s flags_sync
);
    typedef struct packed {
        flags_s meta;
        flags_s sync;
    } state_s;

    state_s s_q;
    state_s s_d;

    always_comb begin
        s_d.meta = flags_raw;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags_sync = s_q.sync;

endmodule : flag_sync

// [sim/qsk_sva.sv]
// Purpose: Checker for burst sequencing, bin mapping and fault lockout
// Assumes: Bound to the controller top with its quiet count
// Notes: Ages count cycles since an event and saturate
`timescale 1ns/1ns
module qsk_sva
    import qsk_pkg::*;
#(
    parameter int unsigned QUIET_COUNT = QUIET_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic feedback_level_above_exit,
    input wire logic feedback_level_above_1v,
    input wire logic drive_pulse_active,
    input wire logic zero_cross_sense_demag_end,
    input wire logic abnormal_overcurrent_fault,
    input wire logic overvoltage_fault,
    input wire logic latch_input,
    input wire logic supply_reset_level,
    input wire logic line_removal,
    input wire logic gate_drive_output,
    input wire logic burst_active,
    input wire logic [7:0] cs_min_code,
    input wire logic [4:0] sensed_bin,
    input wire logic [1:0] fault_mode,
    input wire logic fault_latched
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic gate_q;
    logic [15:0] rise_q, clr_q, dm_q, ex_q;
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (&v) ? v : v + 16'h1;
    endfunction : inc
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gate_q <= 1'b0;
            rise_q <= 16'hFFFF;
            clr_q <= 16'hFFFF;
            dm_q <= 16'hFFFF;
            ex_q <= 16'hFFFF;
        end else begin
            gate_q <= gate_drive_output;
            rise_q <= (gate_drive_output && !gate_q) ? 16'h0 : inc(rise_q);
            clr_q <= (supply_reset_level || line_removal) ? 16'h0 : inc(clr_q);
            dm_q <= zero_cross_sense_demag_end ? 16'h0 : inc(dm_q);
            ex_q <= feedback_level_above_exit ? 16'h0 : inc(ex_q);
        end
    end
    sequence s_trip;
        abnormal_overcurrent_fault || overvoltage_fault || latch_input;
    endsequence
    sequence s_locked;
        ##[1:6] (fault_latched && !gate_drive_output);
    endsequence
    property p_latch_trip;
        s_trip |-> s_locked;
    endproperty
    property p_dark;
        fault_latched |-> !gate_drive_output;
    endproperty
    property p_fault_off;
        fault_mode != FM_NONE && $past(fault_mode) != FM_NONE |-> !gate_drive_output;
    endproperty
    property p_unlatch;
        $fell(fault_latched) |-> clr_q < 16'h8;
    endproperty
    property p_code;
        $stable(sensed_bin) |-> sensed_bin <= BIN_MAX && cs_min_code == CS_MIN_MV[sensed_bin];
    endproperty
    property p_sample;
        $changed(sensed_bin) |-> dm_q < 16'h8;
    endproperty
    property p_quiet;
        $rose(gate_drive_output) && burst_active && $past(burst_active) |-> rise_q >= QUIET_COUNT;
    endproperty
    property p_wait_exit;
        $rose(gate_drive_output) && burst_active |-> ex_q < 16'h8;
    endproperty
    property p_pulse_end;
        $fell(gate_drive_output) && burst_active |->
            !$past(drive_pulse_active) && !$past(drive_pulse_active, 2);
    endproperty
    property p_leave;
        $rose(feedback_level_above_1v) |-> ##[1:6] !burst_active;
    endproperty
    a_latch_trip: assert property (p_latch_trip) else $error("trip not locked");
    a_dark: assert property (p_dark) else $error("drive while latched");
    a_fault_off: assert property (p_fault_off) else $error("drive in fault");
    a_unlatch: assert property (p_unlatch) else $error("latch cleared alone");
    a_code: assert property (p_code) else $error("bin code mismatch");
    a_sample: assert property (p_sample) else $error("bin moved off demag");
    a_quiet: assert property (p_quiet) else $error("burst restart too soon");
    a_wait_exit: assert property (p_wait_exit) else $error("restart without exit");
    a_pulse_end: assert property (p_pulse_end) else $error("pulse cut short");
    a_leave: assert property (p_leave) else $error("burst kept above 1 V");
endmodule : qsk_sva

bind quiet_skip_burst_fault_control qsk_sva #(.QUIET_COUNT(QUIET_COUNT)) u_sva (.*);

// [sim/qsk_power_stage.sv]
// Purpose: Power stage model, drive pulses while gated, demag end after each
// Assumes: Pulse length and period in sys_clk cycles
// Notes: Changes at the falling edge
`timescale 1ns/1ns
module qsk_power_stage #(
    parameter int ON_CYC = 4,
    parameter int PERIOD_CYC = 14
)
(
    input wire logic sys_clk,
    input wire logic gate_drive_output,
    output logic drive_pulse_active,
    output logic zero_cross_sense_demag_end
);
    int phase;
    initial begin
        phase = 0;
        drive_pulse_active = 1'b0;
        zero_cross_sense_demag_end = 1'b0;
    end
    always @(negedge sys_clk) begin
        phase = gate_drive_output ? (phase + 1) % PERIOD_CYC : 0;
        drive_pulse_active <= gate_drive_output && phase >= 1 && phase <= ON_CYC;
        zero_cross_sense_demag_end <= (phase == ON_CYC + 2);
    end
endmodule : qsk_power_stage

// [sim/quiet_skip_burst_fault_control_tb.sv]
// Purpose: Self-checking bench for the quiet-skip burst and fault controller
// Assumes: Shortened quiet and auto-recovery counts
// Notes: Inputs change at the falling edge
`timescale 1ns/1ns
module quiet_skip_burst_fault_control_tb
    import qsk_pkg::*;
    ;
    localparam int QN = 120;
    localparam int AN = 100;
    logic sys_clk = 1'b0, reset = 1'b1, valley_detect = 1'b0;
    logic feedback_level_below_skip = 1'b0, feedback_level_above_exit = 1'b0;
    logic feedback_level_above_1v = 1'b0, freq_at_25khz = 1'b0, latch_input = 1'b0;
    logic abnormal_overcurrent_fault = 1'b0, overvoltage_fault = 1'b0;
    logic nonlatch_fault = 1'b0, autorec_fault = 1'b0, line_removal = 1'b0;
    logic supply_turn_on_level = 1'b0, supply_reset_level = 1'b0;
    logic [4:0] zero_cross_sense_bin = 5'h00;
    logic drive_pulse_active, zero_cross_sense_demag_end, gate_drive_output;
    logic burst_active, fault_latched;
    logic [7:0] cs_min_code;
    logic [4:0] sensed_bin;
    logic [1:0] fault_mode;
    int n_errors = 0;
    int n_tests = 0;
    always #50 sys_clk = ~sys_clk;
    quiet_skip_burst_fault_control #(.QUIET_COUNT(QN), .AUTOREC_COUNT(AN)) u_dut (.*);
    qsk_power_stage u_stage (.*);
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_gate(input logic v, input int max);
        for (int i = 0; i < max && gate_drive_output !== v; i++) tick(1);
        chk(8'(gate_drive_output), 8'(v));
    endtask : wait_gate
    task automatic stop_burst;
        feedback_level_above_exit = 1'b0;
        feedback_level_below_skip = 1'b1;
        wait_gate(1'b0, 60);
        feedback_level_below_skip = 1'b0;
    endtask : stop_burst
    task automatic t_bins;
        logic [4:0] e;
        for (int b = 0; b <= 20; b++) begin
            e = (b > 17) ? BIN_MAX : 5'(b);
            zero_cross_sense_bin = 5'(b);
            tick(30);
            chk(8'(sensed_bin), 8'(e));
            chk(cs_min_code, CS_MIN_MV[e]);
        end
        $display("bin test done");
    endtask : t_bins
    task automatic t_burst;
        int n;
        logic prev;
        n = 0;
        feedback_level_below_skip = 1'b1;
        freq_at_25khz = 1'b1;
        wait_gate(1'b0, 40);
        chk(8'(burst_active), 8'h01);
        feedback_level_below_skip = 1'b0;
        freq_at_25khz = 1'b0;
        feedback_level_above_exit = 1'b1;
        wait_gate(1'b1, 12);
        feedback_level_above_exit = 1'b0;
        feedback_level_below_skip = 1'b1;
        prev = drive_pulse_active;
        for (int i = 0; i < 100 && gate_drive_output; i++) begin
            n += int'(prev && !drive_pulse_active);
            prev = drive_pulse_active;
            tick(1);
        end
        chk(8'(n), 8'h03);
        feedback_level_below_skip = 1'b0;
        feedback_level_above_exit = 1'b1;
        tick(20);
        chk(8'(gate_drive_output), 8'h00);
        wait_gate(1'b1, QN);
        stop_burst();
        tick(QN + 10);
        chk(8'(gate_drive_output), 8'h00);
        feedback_level_above_exit = 1'b1;
        wait_gate(1'b1, 12);
        stop_burst();
        feedback_level_above_1v = 1'b1;
        wait_gate(1'b1, 10);
        chk(8'(burst_active), 8'h00);
        feedback_level_above_1v = 1'b0;
        $display("burst test done");
    endtask : t_burst
    task automatic t_latch;
        for (int k = 0; k < 3; k++) begin
            {abnormal_overcurrent_fault, overvoltage_fault, latch_input} = 3'b100 >> k;
            tick(3);
            {abnormal_overcurrent_fault, overvoltage_fault, latch_input} = 3'b000;
            wait_gate(1'b0, 4);
            tick(3);
            chk(8'(fault_mode), 8'h01);
            supply_turn_on_level = 1'b1;
            tick(6);
            supply_turn_on_level = 1'b0;
            chk(8'(fault_latched), 8'h01);
            chk(8'(gate_drive_output), 8'h00);
            line_removal = (k == 1);
            supply_reset_level = (k != 1);
            tick(5);
            {line_removal, supply_reset_level} = 2'b00;
            tick(4);
            chk(8'(fault_latched), 8'h00);
            chk(8'(fault_mode), 8'h02);
            supply_turn_on_level = 1'b1;
            wait_gate(1'b1, 8);
            supply_turn_on_level = 1'b0;
        end
        $display("latch test done");
    endtask : t_latch
    task automatic t_fault;
        nonlatch_fault = 1'b1;
        wait_gate(1'b0, 8);
        supply_turn_on_level = 1'b1;
        tick(6);
        chk(8'(gate_drive_output), 8'h00);
        chk(8'(fault_mode), 8'h02);
        supply_turn_on_level = 1'b0;
        nonlatch_fault = 1'b0;
        tick(4);
        supply_turn_on_level = 1'b1;
        wait_gate(1'b1, 8);
        supply_turn_on_level = 1'b0;
        autorec_fault = 1'b1;
        wait_gate(1'b0, 8);
        autorec_fault = 1'b0;
        tick(4);
        chk(8'(fault_mode), 8'h03);
        supply_turn_on_level = 1'b1;
        tick(6);
        chk(8'(gate_drive_output), 8'h00);
        supply_turn_on_level = 1'b0;
        tick(AN);
        supply_turn_on_level = 1'b1;
        wait_gate(1'b1, 8);
        supply_turn_on_level = 1'b0;
        $display("fault test done");
    endtask : t_fault
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        tick(2);
        chk({burst_active, gate_drive_output, fault_latched, sensed_bin}, 8'(BIN_RESET));
        chk(cs_min_code, CS_MIN_RESET);
        chk(8'(fault_mode), 8'h00);
        reset = 1'b0;
        wait_gate(1'b1, 8);
        t_bins();
        t_burst();
        t_latch();
        t_fault();
        tally_and_finish();
    end
    // Whole run needs under 1500 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : quiet_skip_burst_fault_control_tb
